// File: verilog/thermal_sense_regs.svh
// Register offsets, field positions, zone codes and timing counts of the thermal sense block.
`ifndef THERMAL_SENSE_REGS_SVH
`define THERMAL_SENSE_REGS_SVH
`define CLK_PERIOD_NS 10
`define REFRESH_TIME_US 100
`define REFRESH_CYCLES ((`REFRESH_TIME_US * 1000) / `CLK_PERIOD_NS)
`define AVERAGE_COUNT 8
`define SETTLE_CYCLES 16
`define ADDR_STRAP 8'h10
`define ADDR_OFFSET 8'h11
`define ADDR_ZONE 8'h12
`define ADDR_THERMAL 8'h13
`define ADDR_POWER 8'h14
`define ADDR_DECODE 8'h15
`define ADDR_STATUS 8'h16
`define ADDR_MASK 8'h17
`define ADDR_PHASE 8'h18
`define ADDR_AVERAGE 8'h19
`define HOT_CODE 8'h55
`define ZONE_97 8'h5a
`define ZONE_94 8'h5e
`define ZONE_91 8'h62
`define ZONE_88 8'h66
`define ZONE_85 8'h6b
`define ZONE_82 8'h71
`define ZONE_75 8'h81
`define STRAP_LIFT_LSB 0
`define STRAP_FLAT_BIT 2
`define STRAP_ACOUSTIC_BIT 3
`define LIFT_INDEX_60 8'h3c
`define LIFT_INDEX_80 8'h50
`define LIFT_INDEX_100 8'h64
`define EV_HOT 0
`define EV_ZONE 1
`define EV_AVERAGE 2
`endif

// File: verilog/thermal_sense_pkg.sv
// Types shared by the thermal sense block.
package thermal_sense_pkg;
    typedef enum logic [1:0] {
        REF_HIGH,
        REF_LOW
    } adc_reference_type;
    typedef struct packed {
        logic [7:0] address;
        logic [7:0] write_data;
        logic write_strobe;
        logic read_strobe;
    } reg_request_type;
    typedef struct packed {
        logic hf_droop_enable;
        logic [7:0] hf_droop_lift_lowpower;
        logic flat_loadline_enable;
        logic acoustic_enable;
    } strap_decode_type;
endpackage

// File: verilog/thermal_sense.sv
// Sense-pin sequencer, thermal zone coder, alert driver and register port.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`include "thermal_sense_regs.svh"
module thermal_sense (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] adc_code,
    input wire logic [7:0] system_power_code,
    input wire logic acoustic_suppression_pin,
    input wire thermal_sense_pkg::reg_request_type bus_request,
    output logic [7:0] read_data,
    output logic adc_reference,
    output logic sense_current_enable,
    output logic thermal_alert_n_out,
    output logic thermal_alert_n_oe,
    output logic hf_droop_enable,
    output logic [7:0] hf_droop_lift_lowpower,
    output logic flat_loadline_enable,
    output logic acoustic_enable,
    output logic interrupt
);
    import thermal_sense_pkg::*;

    // Overview of the block.
    // The block owns one analog sense pin that does three jobs in turn.
    // First it reads a resistor divider that encodes the option straps.
    // Then it reads the same divider with the low reference to learn the pin offset.
    // Last it turns on the sense current and reads the thermistor drop for good.
    // The ADC itself sits outside; this logic only steers it and takes its codes.
    // The reference select and the current enable are the two steering outputs.
    // The ADC code input is treated as a level that is valid once settled.
    // Each capture phase waits a fixed settle count before it takes the code.
    // The settle count is a chosen figure; a slower converter needs a larger one.
    // Strap and offset codes are taken once and held until the next reset.
    // Holding them means a later change on the divider cannot alter the setup.
    // That is the intended trade: a board fault after power-on is not seen here.
    //
    // Sensing phase.
    // Every refresh period one sample is taken and corrected by the offset.
    // The correction saturates at zero rather than wrapping around.
    // A wrapped value would read as a very cold sensor and hide an overheat.
    // Eight corrected samples are summed and divided by eight for the average.
    // The average is kept for software; the alert and zone use the latest sample.
    // Using the latest sample keeps the alert quick at the cost of some noise.
    // There is no hysteresis on the alert, so a noisy sensor may chatter it.
    //
    // Zone coding.
    // A lower thermal voltage means a hotter thermistor.
    // Each zone level that the voltage falls to sets one more bit from the bottom.
    // The hottest level sets every bit; the alert uses the same code but fires only strictly below it.
    // Zone levels are codes chosen for the assumed ADC scale and are macros.
    //
    // Alert pin.
    // The alert is open drain: the data output is tied low.
    // Only the enable moves, and it goes high to pull the line low.
    // A board pull-up must hold the line high while the enable is low.
    // Driving the line high would fight other devices that share it.
    //
    // Strap decode.
    // The two low strap bits select the light-load droop lift index or off.
    // One strap bit holds the output target flat, independent of load.
    // One strap bit allows acoustic suppression, gated by its pin.
    // The pin is read live, so suppression follows it after one clock.
    //
    // System power.
    // The digitised system power code is latched every clock and read back.
    // Full scale on the analog side is the all-ones code.
    //
    // Register port.
    // A read strobe returns data in the following cycle only; otherwise zero.
    // Returning zero when idle keeps a shared read bus free of stale values.
    // Writes reach only the status and mask registers; all else is read only.
    // Status bits are sticky and cleared by writing a one to them.
    // When an event and a clear meet in one cycle the event wins.
    // Losing an event to a racing clear would hide a hot crossing from software.
    // The interrupt is high while any unmasked status bit is set.
    //
    // Limitations.
    // Phase order is fixed and cannot be restarted except by reset.
    // The refresh period assumes the system clock named in the header.
    // A different clock rate needs the clock period macro changed to match.
    // The average is readable but raises only its own status event.
    //
    // Reset values.
    // The thermal register starts at all ones, which reads as cold.
    // Starting cold keeps the alert released until the first real sample.
    // The zone register therefore starts at zero, below the lowest zone.
    // The reference select starts at the high reference for the strap read.
    // The sense current starts off so the strap read is not disturbed.
    // Status and mask start clear, so no interrupt follows reset.
    //
    // Timing summary.
    // Strap code is taken after the settle count from the end of reset.
    // Offset code is taken one settle count later.
    // The first thermal sample follows one refresh period after that.
    // Zone and alert follow each sample by one clock.
    // The interrupt follows the status change in the same clock.

    // Sequencer phases after power-on.
    typedef enum logic [1:0] {
        PHASE_STRAP,
        PHASE_OFFSET,
        PHASE_SENSE
    } phase_type;

    phase_type phase; // Current phase of the sense pin.
    logic [15:0] timer; // Settle and refresh timer.
    logic [7:0] strap; // Captured option straps.
    logic [7:0] offset; // Captured pin offset.
    logic [7:0] thermal; // Latest offset-corrected sample.
    logic [10:0] accumulator; // Sum of samples for the average.
    logic [2:0] sample_count; // Samples in the running sum.
    logic [7:0] average; // Averaged thermal voltage code.
    logic [7:0] zone; // Thermometer zone code.
    logic [7:0] power; // Latched system power code.
    logic [2:0] status; // Sticky events.
    logic [2:0] mask; // Interrupt enables.
    logic hot; // Registered alert condition.

    // Subtraction saturates at zero so a noisy sample cannot wrap to a cold reading.
    function automatic logic [7:0] minus_offset(input logic [7:0] sample, input logic [7:0] base);
        minus_offset = (sample > base) ? sample - base : 8'h00;
    endfunction

    // Lower thermal voltage means hotter, so each crossed level adds one zone bit.
    function automatic logic [7:0] zone_code(input logic [7:0] volts);
        logic [7:0] code;
        code = 8'h00;
        if (volts <= `ZONE_75) begin
            code = 8'h01;
        end
        if (volts <= `ZONE_82) begin
            code = 8'h03;
        end
        if (volts <= `ZONE_85) begin
            code = 8'h07;
        end
        if (volts <= `ZONE_88) begin
            code = 8'h0f;
        end
        if (volts <= `ZONE_91) begin
            code = 8'h1f;
        end
        if (volts <= `ZONE_94) begin
            code = 8'h3f;
        end
        if (volts <= `ZONE_97) begin
            code = 8'h7f;
        end
        if (volts <= `HOT_CODE) begin
            code = 8'hff;
        end
        zone_code = code;
    endfunction

    // Decode and next-value wires.
    wire settled = (timer == 16'(`SETTLE_CYCLES - 1));
    wire refresh = (timer == 16'(`REFRESH_CYCLES - 1));
    wire [7:0] next_thermal = minus_offset(adc_code, offset);
    wire average_done = (sample_count == 3'(`AVERAGE_COUNT - 1));
    wire [10:0] next_sum = accumulator + 11'(next_thermal);
    wire [7:0] next_average = next_sum[10:3];
    wire next_hot = (thermal < `HOT_CODE);
    wire [7:0] next_zone = zone_code(thermal);
    wire [1:0] lift_field = strap[`STRAP_LIFT_LSB +: 2];
    wire [7:0] next_lift = (lift_field == 2'b00) ? `LIFT_INDEX_60 :
                           (lift_field == 2'b01) ? `LIFT_INDEX_80 :
                           (lift_field == 2'b10) ? `LIFT_INDEX_100 : 8'h00;
    wire next_acoustic = strap[`STRAP_ACOUSTIC_BIT] & acoustic_suppression_pin;
    wire wr = bus_request.write_strobe;
    wire [7:0] addr = bus_request.address;
    wire [2:0] clear_bits = (wr && addr == `ADDR_STATUS) ? bus_request.write_data[2:0] : 3'h0;
    wire [2:0] events = {refresh && phase == PHASE_SENSE && average_done,
                         next_zone != zone, next_hot && !hot};
    wire [7:0] next_read =
        (addr == `ADDR_STRAP) ? strap :
        (addr == `ADDR_OFFSET) ? offset :
        (addr == `ADDR_ZONE) ? zone :
        (addr == `ADDR_THERMAL) ? thermal :
        (addr == `ADDR_POWER) ? power :
        (addr == `ADDR_DECODE) ? {4'h0, acoustic_enable, flat_loadline_enable, lift_field} :
        (addr == `ADDR_STATUS) ? {5'h0, status} :
        (addr == `ADDR_MASK) ? {5'h0, mask} :
        (addr == `ADDR_PHASE) ? {6'h0, phase} :
        (addr == `ADDR_AVERAGE) ? average : 8'h00;

    // Phase sequencer; the strap and offset codes are taken once and then held.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phase <= PHASE_STRAP;
            timer <= 16'h0000;
            strap <= 8'h00;
            offset <= 8'h00;
            adc_reference <= REF_HIGH[0];
            sense_current_enable <= 1'b0;
        end else begin
            unique case (phase)
                PHASE_STRAP: begin
                    timer <= settled ? 16'h0000 : timer + 16'h0001;
                    if (settled) begin
                        strap <= adc_code;
                        adc_reference <= REF_LOW[0];
                        phase <= PHASE_OFFSET;
                    end
                end
                PHASE_OFFSET: begin
                    timer <= settled ? 16'h0000 : timer + 16'h0001;
                    if (settled) begin
                        offset <= adc_code;
                        sense_current_enable <= 1'b1;
                        phase <= PHASE_SENSE;
                    end
                end
                PHASE_SENSE: begin
                    timer <= refresh ? 16'h0000 : timer + 16'h0001;
                end
            endcase
        end
    end

    // Thermal sample, its eight-sample average and the zone code.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            thermal <= 8'hff;
            accumulator <= 11'h000;
            sample_count <= 3'h0;
            average <= 8'h00;
            zone <= 8'h00;
        end else begin
            zone <= next_zone;
            if (phase == PHASE_SENSE && refresh) begin
                thermal <= next_thermal;
                sample_count <= sample_count + 3'h1;
                accumulator <= average_done ? 11'h000 : next_sum;
                if (average_done) begin
                    average <= next_average;
                end
            end
        end
    end

    // Alert pin: the enable goes high only to pull low, never drives high.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hot <= 1'b0;
            thermal_alert_n_out <= 1'b0;
            thermal_alert_n_oe <= 1'b0;
        end else begin
            hot <= next_hot;
            thermal_alert_n_out <= 1'b0;
            thermal_alert_n_oe <= next_hot;
        end
    end

    // Strap decode outputs and the system power code.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hf_droop_enable <= 1'b0;
            hf_droop_lift_lowpower <= 8'h00;
            flat_loadline_enable <= 1'b0;
            acoustic_enable <= 1'b0;
            power <= 8'h00;
        end else begin
            hf_droop_enable <= (lift_field != 2'b11);
            hf_droop_lift_lowpower <= next_lift;
            flat_loadline_enable <= strap[`STRAP_FLAT_BIT];
            acoustic_enable <= next_acoustic;
            power <= system_power_code;
        end
    end

    // Register port: sticky status with set winning over a write-one clear.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status <= 3'h0;
            mask <= 3'h0;
            read_data <= 8'h00;
            interrupt <= 1'b0;
        end else begin
            status <= (status & ~clear_bits) | events;
            if (wr && addr == `ADDR_MASK) begin
                mask <= bus_request.write_data[2:0];
            end
            read_data <= bus_request.read_strobe ? next_read : 8'h00;
            interrupt <= |(((status & ~clear_bits) | events) & mask);
        end
    end
endmodule

// File: test/ntc_network_model.sv
// Behavioural resistor and thermistor network on the sense pin.
`timescale 1ns/100ps
module ntc_network_model (
    input wire logic adc_reference,
    input wire logic sense_current_enable,
    input wire logic [7:0] strap_code,
    input wire logic [7:0] offset_code,
    input wire logic [7:0] thermal_code,
    output logic [7:0] adc_code
);
    // High reference reads the divider strap; the sense current adds the thermistor drop to the offset.
    assign adc_code = !adc_reference ? strap_code : offset_code + (sense_current_enable ? thermal_code : 8'h00);
endmodule

// File: test/thermal_sense_properties.sv
// Port checks for the thermal sense block.
`timescale 1ns/100ps
module thermal_sense_properties
    import thermal_sense_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire thermal_sense_pkg::reg_request_type bus_request,
    input wire logic [7:0] read_data,
    input wire logic adc_reference,
    input wire logic sense_current_enable,
    input wire logic thermal_alert_n_out,
    input wire logic thermal_alert_n_oe,
    input wire logic hf_droop_enable,
    input wire logic [7:0] hf_droop_lift_lowpower,
    input wire logic flat_loadline_enable,
    input wire logic acoustic_suppression_pin,
    input wire logic acoustic_enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // The strap and offset windows each last fifteen cycles.
    sequence strap_window; !adc_reference [*8] ##1 !adc_reference [*7]; endsequence
    sequence offset_window; !sense_current_enable [*8] ##1 !sense_current_enable [*7]; endsequence
    strap_phase_a: assert property ($fell(reset) |-> strap_window ##[1:4] adc_reference) else $error("strap window");
    offset_phase_a: assert property ($rose(adc_reference) |-> offset_window ##[1:4] sense_current_enable) else $error("offset window");
    ref_hold_a: assert property (adc_reference |=> adc_reference) else $error("reference returned high");
    current_ref_a: assert property (sense_current_enable |-> adc_reference) else $error("current on high ref");
    alert_drive_a: assert property (thermal_alert_n_oe |-> !thermal_alert_n_out) else $error("alert driven high");
    alert_phase_a: assert property ($rose(thermal_alert_n_oe) |-> $past(sense_current_enable)) else $error("early alert");
    lift_decode_a: assert property (hf_droop_enable == (hf_droop_lift_lowpower != 8'h00)
        && hf_droop_lift_lowpower inside {8'h00, 8'h3c, 8'h50, 8'h64}) else $error("lift decode");
    capture_hold_a: assert property (sense_current_enable && $past(sense_current_enable) |->
        $stable(hf_droop_lift_lowpower) && $stable(flat_loadline_enable)) else $error("strap moved");
    acoustic_gate_a: assert property (acoustic_enable |-> $past(acoustic_suppression_pin)) else $error("acoustic");
    read_idle_a: assert property (!bus_request.read_strobe |=> read_data == 8'h00) else $error("read data idle");
endmodule
bind thermal_sense thermal_sense_properties u_thermal_sense_properties (.clk_sys, .reset, .bus_request, .read_data,
    .adc_reference, .sense_current_enable, .thermal_alert_n_out, .thermal_alert_n_oe, .hf_droop_enable,
    .hf_droop_lift_lowpower, .flat_loadline_enable, .acoustic_suppression_pin, .acoustic_enable);

// File: test/thermal_sense_bench.sv
// Self-checking bench for the thermal sense block.
`timescale 1ns/100ps
`include "thermal_sense_regs.svh"
module thermal_sense_bench;
    import thermal_sense_pkg::*;
    typedef struct packed {logic [7:0] s; logic p; logic [7:0] l; logic f; logic a;} row_type;
    row_type rows [4] = '{'{8'h00, 1, 8'h3c, 0, 0}, '{8'h05, 0, 8'h50, 1, 0}, '{8'h0a, 1, 8'h64, 0, 1},
        '{8'h0f, 0, 8'h00, 1, 0}};
    logic clk_sys = 0, reset = 1, pin = 0;
    logic [7:0] strap = 8'h00, offset = 8'h20, thermal = 8'h90, power = 8'hff;
    wire [7:0] adc_code, read_data, lift;
    wire adc_ref, cur, a_out, a_oe, hf_en, flat, acou, irq;
    wire alert_n = a_oe ? a_out : 1'b1; // The board pull-up holds the line while released.
    reg_request_type req = '0;
    int err_total = 0, total_checks = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    // A hang costs a mismatch and ends the run.
    always @(posedge clk_sys) if (++cycles > 40000) begin
        err_total++;
        test_done();
    end
    ntc_network_model u_ntc_network_model (.adc_reference(adc_ref), .sense_current_enable(cur), .strap_code(strap),
        .offset_code(offset), .thermal_code(thermal), .adc_code);
    thermal_sense u_thermal_sense (.clk_sys, .reset, .adc_code, .system_power_code(power),
        .acoustic_suppression_pin(pin), .bus_request(req), .read_data, .adc_reference(adc_ref),
        .sense_current_enable(cur), .thermal_alert_n_out(a_out), .thermal_alert_n_oe(a_oe), .hf_droop_enable(hf_en),
        .hf_droop_lift_lowpower(lift), .flat_loadline_enable(flat), .acoustic_enable(acou), .interrupt(irq));
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Read data is looked at in the one cycle that it stands.
    task automatic rd_reg(logic [7:0] a, logic [7:0] exp, string name);
        @(posedge clk_sys) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys) req.read_strobe <= 1'b0;
        #1 check(name, exp, read_data);
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys) req.write_strobe <= 1'b0;
    endtask
    // Five cycles of reset, then time for both capture phases.
    task automatic power_on(row_type r);
        @(posedge clk_sys) reset <= 1'b1;
        strap <= r.s;
        pin <= r.p;
        repeat (4) @(posedge clk_sys);
        #1 check("reset outputs", 8'h00, {a_oe, irq, adc_ref, cur});
        @(posedge clk_sys) reset <= 1'b0;
        repeat (40) @(posedge clk_sys);
        #1;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        foreach (rows[i]) begin
            power_on(rows[i]);
            check("lift", rows[i].l, lift);
            check("droop enable", {7'h00, rows[i].l != 8'h00}, {7'h00, hf_en});
            check("flat", {7'h00, rows[i].f}, {7'h00, flat});
            check("acoustic", {7'h00, rows[i].a}, {7'h00, acou});
            rd_reg(`ADDR_STRAP, rows[i].s, "strap");
            rd_reg(`ADDR_OFFSET, offset, "offset");
            rd_reg(`ADDR_PHASE, 8'h02, "phase");
        end
        wr_reg(`ADDR_MASK, 8'h01);
        strap <= 8'h03;
        thermal <= 8'h50;
        repeat (10100) @(posedge clk_sys);
        rd_reg(`ADDR_THERMAL, 8'h50, "thermal");
        rd_reg(`ADDR_ZONE, 8'hff, "zone hot");
        check("alert", 8'h00, {7'h00, alert_n});
        check("irq set", 8'h01, {7'h00, irq});
        wr_reg(`ADDR_STATUS, 8'h01);
        wr_reg(`ADDR_THERMAL, 8'h00);
        #1 check("irq clear", 8'h00, {7'h00, irq});
        rd_reg(`ADDR_THERMAL, 8'h50, "thermal ro");
        rd_reg(8'h20, 8'h00, "unmapped");
        rd_reg(`ADDR_POWER, 8'hff, "power");
        rd_reg(`ADDR_STRAP, 8'h0f, "strap kept");
        check("lift kept", 8'h00, lift);
        @(posedge clk_sys) thermal <= 8'h60;
        repeat (10100) @(posedge clk_sys);
        rd_reg(`ADDR_ZONE, 8'h1f, "zone 91");
        check("alert release", 8'h01, {7'h00, alert_n});
        test_done();
    end
endmodule
